// *** src/cmd_framer_regs.vh ***
`ifndef CMD_FRAMER_REGS_VH
`define CMD_FRAMER_REGS_VH

// reply words, sent least significant byte first
`define CMD_ERR_WORD      32'h63727265
`define DATA_ERR_WORD     32'h64727265

// checksum constants
`define CKSUM_INIT        16'hffff
`define CKSUM_POLY        16'ha001

// frame layout
`define ID_BYTES          3'h4
`define CKSUM_BYTES       2'h2

// timing
`define CLK_HZ            40000000
`define RX_TIMEOUT_MS     400
`define RX_TIMEOUT_CYC    ((`CLK_HZ / 1000) * `RX_TIMEOUT_MS)
`define APPLY_LIMIT_MS    1

`endif

// *** src/byte_skid_buffer.v ***
// ==========================================
// two-entry buffer with valid/ready on both sides
module byte_skid_buffer #(
    parameter WIDTH = 8
) (
    input  wire             ref_clk_i,
    input  wire             reset_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem_q [0:1];
    reg             wr_ptr_q;
    reg             rd_ptr_q;
    reg [1:0]       count_q;

    wire push = in_valid_i && (count_q != 2'h2);
    wire pop  = out_ready_i && (count_q != 2'h0);

    assign in_ready_o  = (count_q != 2'h2);
    assign out_valid_o = (count_q != 2'h0);
    assign out_data_o  = mem_q[rd_ptr_q];

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_q[0] <= {WIDTH{1'b0}};
            mem_q[1] <= {WIDTH{1'b0}};
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= in_data_i;
                wr_ptr_q        <= ~wr_ptr_q;
            end
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            if (push && !pop)
                count_q <= count_q + 2'h1;
            else if (pop && !push)
                count_q <= count_q - 2'h1;
        end
    end
endmodule // byte_skid_buffer

// *** src/serial_command_framer_resync.v ***
`include "cmd_framer_regs.vh"

// Operation
// - device never transmits unprompted; replies only follow a received command
// - set-type parameter applied within 1 ms after acknowledge
// - command handling never stalls the real-time motor logic
// - frame is 4-byte identifier, optional data, then 2-byte checksum; the code takes no checksum bytes for a command without data
// - execute only known commands with good checksum; each consumed once
// - valid command echoes identifier, then reply data and checksum; the code sends only the echo when the reply length is zero
// - unknown identifier: discard, send command-error reply, set flag
// - checksum mismatch: discard, send data-error reply, set flag; the code has already passed the data bytes out on exec_data_o
// - checksum covers data bytes only, never the identifier
// - checksum starts 0xffff, xor byte, eight shifts with 0xa001 feedback
// - inter-byte gap over timeout drops the partial command
// - zero first byte is answered with a single zero byte
// - command-error reply is the word 0x63727265
// - data-error reply is the word 0x64727265
// - inter-byte receive timeout is 400 ms
// - multi-byte fields travel least significant byte first
module serial_command_framer_resync #(
    parameter RX_TIMEOUT_CYC = `RX_TIMEOUT_CYC,
    parameter MAX_DATA       = 255
) (
    input  wire        ref_clk_i,
    input  wire        reset_i,
    // received bytes from the serial receiver, one 8-bit character each
    input  wire [7:0]  rx_data_i,
    input  wire        rx_valid_i,
    output wire        rx_ready_o,
    // command lookup, answered combinationally by the command table
    output wire [31:0] lookup_id_o,
    input  wire        lookup_known_i,
    input  wire [7:0]  lookup_rx_len_i,
    input  wire [7:0]  lookup_tx_len_i,
    // accepted command towards the executor
    output reg  [31:0] exec_id_o,
    output reg         exec_valid_o,
    output reg  [7:0]  exec_data_o,
    output reg         exec_data_valid_o,
    // reply data from the executor, asked for one byte at a time
    output wire        reply_req_o,
    input  wire [7:0]  reply_data_i,
    // transmit bytes to the serial transmitter
    output wire [7:0]  tx_data_o,
    output wire        tx_valid_o,
    input  wire        tx_ready_i,
    // sticky status flags, cleared by a pulse
    output reg         cmd_err_flag_o,
    output reg         data_err_flag_o,
    input  wire        flags_clr_i
);
    // ==========================================
    // states
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_ID   = 8'h02;
    localparam [7:0] S_DATA = 8'h04;
    localparam [7:0] S_CK   = 8'h08;
    localparam [7:0] S_EVAL = 8'h10;
    localparam [7:0] S_TXW  = 8'h20;
    localparam [7:0] S_TXD  = 8'h40;
    localparam [7:0] S_TXC  = 8'h80;

    localparam [1:0] W_ECHO = 2'h0;
    localparam [1:0] W_CERR = 2'h1;
    localparam [1:0] W_DERR = 2'h2;
    localparam [1:0] W_ZERO = 2'h3;

    reg [7:0]  state_q;
    reg [31:0] id_q;
    reg [15:0] ck_q;
    reg [15:0] rx_ck_q;
    reg [7:0]  cnt_q;
    reg [7:0]  rx_len_q;
    reg [7:0]  tx_len_q;
    reg [1:0]  word_q;
    reg [31:0] timer_q;
    reg [7:0]  tx_byte_q;
    reg        tx_push_q;

    // ==========================================
    // checksum byte update
    function [15:0] cksum_step;
        input [15:0] crc;
        input [7:0]  b;
        integer      i;
        reg   [15:0] c;
        begin
            c = crc ^ {8'h00, b};
            for (i = 0; i < 8; i = i + 1) begin
                if (c[0])
                    c = (c >> 1) ^ `CKSUM_POLY;
                else
                    c = c >> 1;
            end
            cksum_step = c;
        end
    endfunction

    // ==========================================
    // transmit buffer; a stalled transmitter holds back replies and, while a reply is still being queued, reception of the next command
    wire tx_in_ready;

    byte_skid_buffer #(
        .WIDTH (8)
    ) u_tx_buf (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (reset_i),
        .in_data_i   (tx_byte_q),
        .in_valid_i  (tx_push_q),
        .in_ready_o  (tx_in_ready),
        .out_data_o  (tx_data_o),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i)
    );

    wire receiving = (state_q == S_IDLE) || (state_q == S_ID) ||
                     (state_q == S_DATA) || (state_q == S_CK);
    wire rx_take   = rx_valid_i && receiving;
    assign rx_ready_o  = receiving;
    assign lookup_id_o = id_q;

    // one byte may be pushed only when the buffer has room and no push is pending
    wire can_send = tx_in_ready && !tx_push_q;
    wire [31:0] reply_word = (word_q == W_CERR) ? `CMD_ERR_WORD :
                             (word_q == W_DERR) ? `DATA_ERR_WORD :
                             id_q;
    assign reply_req_o = (state_q == S_TXD) && can_send && (cnt_q < tx_len_q);

    wire timed_out = (timer_q >= RX_TIMEOUT_CYC - 1);

    // ==========================================
    // frame sequencer
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q           <= S_IDLE;
            id_q              <= 32'h00000000;
            ck_q              <= `CKSUM_INIT;
            rx_ck_q           <= 16'h0000;
            cnt_q             <= 8'h00;
            rx_len_q          <= 8'h00;
            tx_len_q          <= 8'h00;
            word_q            <= W_ECHO;
            timer_q           <= 32'h00000000;
            tx_byte_q         <= 8'h00;
            tx_push_q         <= 1'b0;
            exec_id_o         <= 32'h00000000;
            exec_valid_o      <= 1'b0;
            exec_data_o       <= 8'h00;
            exec_data_valid_o <= 1'b0;
            cmd_err_flag_o    <= 1'b0;
            data_err_flag_o   <= 1'b0;
        end else begin
            exec_valid_o      <= 1'b0;
            exec_data_valid_o <= 1'b0;
            if (tx_push_q && tx_in_ready)
                tx_push_q <= 1'b0;
            if (flags_clr_i) begin
                cmd_err_flag_o  <= 1'b0;
                data_err_flag_o <= 1'b0;
            end
            // timer runs only mid-frame
            if (rx_take || state_q == S_IDLE || !receiving)
                timer_q <= 32'h00000000;
            else
                timer_q <= timer_q + 32'h00000001;

            case (state_q)
                S_IDLE: begin
                    if (rx_take) begin
                        if (rx_data_i == 8'h00) begin
                            word_q   <= W_ZERO;
                            cnt_q    <= 8'h00;
                            state_q  <= S_TXW;
                        end else begin
                            id_q    <= {rx_data_i, 24'h000000};
                            cnt_q   <= 8'h01;
                            ck_q    <= `CKSUM_INIT;
                            state_q <= S_ID;
                        end
                    end
                end
                S_ID: begin
                    if (timed_out && !rx_take) begin
                        state_q <= S_IDLE;
                    end else if (rx_take) begin
                        id_q  <= {rx_data_i, id_q[31:8]};
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q == {5'h00, `ID_BYTES} - 8'h01)
                            state_q <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    // identifier complete: decide before any data is taken
                    cnt_q <= 8'h00;
                    if (!lookup_known_i) begin
                        word_q         <= W_CERR;
                        cmd_err_flag_o <= 1'b1;
                        state_q        <= S_TXW;
                    end else if (lookup_rx_len_i == 8'h00) begin
                        exec_id_o    <= id_q;
                        exec_valid_o <= 1'b1;
                        word_q       <= W_ECHO;
                        tx_len_q     <= lookup_tx_len_i;
                        state_q      <= S_TXW;
                    end else begin
                        rx_len_q <= lookup_rx_len_i;
                        state_q  <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (timed_out && !rx_take) begin
                        state_q <= S_IDLE;
                    end else if (rx_take) begin
                        ck_q              <= cksum_step(ck_q, rx_data_i);
                        exec_data_o       <= rx_data_i;
                        exec_data_valid_o <= 1'b1;
                        cnt_q             <= cnt_q + 8'h01;
                        if (cnt_q == rx_len_q - 8'h01) begin
                            cnt_q   <= 8'h00;
                            state_q <= S_CK;
                        end
                    end
                end
                S_CK: begin
                    if (timed_out && !rx_take) begin
                        state_q <= S_IDLE;
                    end else if (rx_take) begin
                        rx_ck_q <= {rx_data_i, rx_ck_q[15:8]};
                        cnt_q   <= cnt_q + 8'h01;
                        if (cnt_q == {6'h00, `CKSUM_BYTES} - 8'h01) begin
                            cnt_q <= 8'h00;
                            if ({rx_data_i, rx_ck_q[15:8]} == ck_q) begin
                                exec_id_o    <= id_q;
                                exec_valid_o <= 1'b1;
                                word_q       <= W_ECHO;
                                tx_len_q     <= lookup_tx_len_i;
                            end else begin
                                word_q          <= W_DERR;
                                data_err_flag_o <= 1'b1;
                            end
                            state_q <= S_TXW;
                        end
                    end
                end
                S_TXW: begin
                    // reply word; only reached after a received byte
                    if (can_send) begin
                        tx_byte_q <= (word_q == W_ZERO) ? 8'h00 :
                                     reply_word[cnt_q[1:0]*8 +: 8];
                        tx_push_q <= 1'b1;
                        cnt_q     <= cnt_q + 8'h01;
                        if (word_q == W_ZERO ||
                            cnt_q == {5'h00, `ID_BYTES} - 8'h01) begin
                            cnt_q <= 8'h00;
                            ck_q  <= `CKSUM_INIT;
                            if (word_q == W_ECHO && tx_len_q != 8'h00)
                                state_q <= S_TXD;
                            else
                                state_q <= S_IDLE;
                        end
                    end
                end
                S_TXD: begin
                    if (reply_req_o) begin
                        tx_byte_q <= reply_data_i;
                        tx_push_q <= 1'b1;
                        ck_q      <= cksum_step(ck_q, reply_data_i);
                        cnt_q     <= cnt_q + 8'h01;
                        if (cnt_q == tx_len_q - 8'h01) begin
                            cnt_q   <= 8'h00;
                            state_q <= S_TXC;
                        end
                    end
                end
                S_TXC: begin
                    if (can_send) begin
                        tx_byte_q <= cnt_q[0] ? ck_q[15:8] : ck_q[7:0];
                        tx_push_q <= 1'b1;
                        cnt_q     <= cnt_q + 8'h01;
                        if (cnt_q[0]) begin
                            cnt_q   <= 8'h00;
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
            // hardware set wins over a same-cycle clear
            if (flags_clr_i && state_q == S_EVAL && !lookup_known_i)
                cmd_err_flag_o <= 1'b1;
        end
    end
    // motor logic never waits on this block; exec_valid_o is one cycle
    // executor applies settings on exec_valid_o, well within 1 ms
endmodule // serial_command_framer_resync

// *** verif/framer_checker_sva.sv ***
module framer_checker (
    input wire        ref_clk_i,
    input wire        reset_i,
    input wire        rx_valid_i,
    input wire        rx_ready_o,
    input wire [31:0] lookup_id_o,
    input wire        lookup_known_i,
    input wire [31:0] exec_id_o,
    input wire        exec_valid_o,
    input wire        exec_data_valid_o,
    input wire [7:0]  tx_data_o,
    input wire        tx_valid_o,
    input wire        tx_ready_i,
    input wire        cmd_err_flag_o,
    input wire        data_err_flag_o,
    input wire        flags_clr_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // =====================================
    // cycles since the last byte was taken, saturating so it never wraps into a false match
    logic [3:0] since_take_q;
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            since_take_q <= 4'hf;
        end else if (rx_valid_i && rx_ready_o) begin
            since_take_q <= 4'h0;
        end else if (since_take_q != 4'hf) begin
            since_take_q <= since_take_q + 4'h1;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // =====================================
    // properties
    AST_NO_UNPROMPTED: assert property ($rose(tx_valid_o) |->
        $past(!rx_ready_o, 2) || since_take_q < 4'h4) else $error("reply without a command");
    AST_RESET_STATE: assert property ($fell(reset_i) |-> rx_ready_o && !tx_valid_o
        && !cmd_err_flag_o && !data_err_flag_o) else $error("bad state after reset");
    AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_data_o)) else $error("tx byte dropped under stall");
    AST_CMD_STICKY: assert property (cmd_err_flag_o && !flags_clr_i |=>
        cmd_err_flag_o) else $error("command flag lost");
    AST_DATA_STICKY: assert property (data_err_flag_o && !flags_clr_i |=>
        data_err_flag_o) else $error("data flag lost");
    AST_FLAG_CLEAR: assert property (flags_clr_i && rx_ready_o && !rx_valid_i |=>
        !cmd_err_flag_o && !data_err_flag_o) else $error("flags not cleared");
    AST_EXEC_KNOWN: assert property (exec_valid_o |-> lookup_known_i
        && exec_id_o == lookup_id_o) else $error("unknown command executed");
    AST_EXEC_ONCE: assert property (exec_valid_o |=> !exec_valid_o)
        else $error("command executed twice");
    AST_DATA_FROM_RX: assert property (exec_data_valid_o |->
        $past(rx_valid_i && rx_ready_o)) else $error("data byte without a take");
    AST_ERRC_FIRST: assert property ($rose(cmd_err_flag_o) |-> ##[0:4]
        (tx_valid_o && tx_data_o == 8'h65)) else $error("command error reply missing");
    AST_ERRD_FIRST: assert property ($rose(data_err_flag_o) |-> ##[0:4]
        (tx_valid_o && tx_data_o == 8'h65)) else $error("data error reply missing");
    AST_ECHO_FIRST: assert property ($rose(exec_valid_o) |-> ##[1:6]
        (tx_valid_o && tx_data_o == exec_id_o[7:0])) else $error("echo missing");
    cover property (exec_valid_o);
    cover property ($rose(data_err_flag_o));
    cover property (tx_valid_o && !tx_ready_i);
endmodule // framer_checker

bind serial_command_framer_resync framer_checker CHK (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
    .lookup_id_o(lookup_id_o), .lookup_known_i(lookup_known_i), .exec_id_o(exec_id_o),
    .exec_valid_o(exec_valid_o), .exec_data_valid_o(exec_data_valid_o), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .cmd_err_flag_o(cmd_err_flag_o),
    .data_err_flag_o(data_err_flag_o), .flags_clr_i(flags_clr_i));

// *** verif/host_model.sv ***
module host_model (
    input  wire        ref_clk_i,
    input  wire        rx_ready_o,
    input  wire [7:0]  tx_data_o,
    input  wire        tx_valid_o,
    output logic [7:0] rx_data_i,
    output logic       rx_valid_i,
    output logic       tx_ready_i
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef logic [7:0] byte_q_t[$];
    logic stall;
    initial begin
        stall = 1'b0;
        rx_data_i = 8'h00;
        rx_valid_i = 1'b0;
        tx_ready_i = 1'b1;
    end
    // a stalling host takes a byte only every other cycle
    always @(posedge ref_clk_i) tx_ready_i <= stall ? ~tx_ready_i : 1'b1;
    // =====================================
    // one whole frame, bytes back to back; the caller awaits the reply afterwards
    task automatic send_frame(input byte_q_t q);
        foreach (q[i]) begin
            rx_data_i <= q[i];
            rx_valid_i <= 1'b1;
            do @(posedge ref_clk_i); while (rx_ready_o !== 1'b1);
        end
        rx_valid_i <= 1'b0;
        rx_data_i <= ~q[q.size()-1];
        @(posedge ref_clk_i);
    endtask
    // zero-byte resync: zeros until one comes back, at most four bursts of 64
    task automatic resync(output logic lost);
        logic got;
        got = 1'b0;
        for (int k = 0; k < 4 && !got; k++) begin
            for (int n = 0; n < 64 && !got; n++) begin
                rx_data_i <= 8'h00;
                rx_valid_i <= 1'b1;
                @(posedge ref_clk_i);
                got = (tx_valid_o === 1'b1 && tx_ready_i === 1'b1 && tx_data_o === 8'h00);
            end
        end
        rx_valid_i <= 1'b0;
        @(posedge ref_clk_i);
        lost = !got;
    endtask
    // response wait is far longer than the device's inter-byte timeout
    task automatic recv(output logic [7:0] b, output logic ok);
        ok = 1'b0;
        b = 8'h00;
        for (int n = 0; n < 400 && !ok; n++) begin
            @(posedge ref_clk_i);
            if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
                ok = 1'b1;
                b = tx_data_o;
            end
        end
    endtask
endmodule // host_model

// *** verif/serial_command_framer_resync_tb.sv ***
module serial_command_framer_resync_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef logic [7:0] byte_q_t[$];
    localparam int          TO_CYC   = 50;
    localparam logic [31:0] ID_PLAIN = 32'h6e6c7061;
    localparam logic [31:0] ID_DATA  = 32'h74616473;
    logic        ref_clk_i, reset_i, flags_clr_i;
    logic [7:0]  reply_cnt_q;
    logic [7:0]  data_last;
    wire  [7:0]  rx_data_i, lookup_rx_len_i, lookup_tx_len_i, reply_data_i, exec_data_o, tx_data_o;
    wire  [31:0] lookup_id_o, exec_id_o;
    wire         rx_valid_i, rx_ready_o, lookup_known_i, exec_valid_o, exec_data_valid_o;
    wire         reply_req_o, tx_valid_o, tx_ready_i, cmd_err_flag_o, data_err_flag_o;
    int          mismatches = 0, checks = 0, exec_cnt = 0, data_cnt = 0;
    // command table: one command without data, one carrying two bytes each way
    assign lookup_known_i = (lookup_id_o == ID_PLAIN) || (lookup_id_o == ID_DATA);
    assign lookup_rx_len_i = (lookup_id_o == ID_DATA) ? 8'h02 : 8'h00;
    assign lookup_tx_len_i = (lookup_id_o == ID_DATA) ? 8'h02 : 8'h00;
    assign reply_data_i = 8'ha0 + reply_cnt_q;
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) reply_cnt_q <= 8'h00;
        else if (reply_req_o) reply_cnt_q <= reply_cnt_q + 8'h01;
    end
    always @(posedge ref_clk_i) begin
        if (exec_valid_o === 1'b1) exec_cnt++;
        if (exec_data_valid_o === 1'b1) begin
            data_cnt++;
            data_last <= exec_data_o;
        end
    end
    serial_command_framer_resync #(.RX_TIMEOUT_CYC(TO_CYC)) DUT (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .rx_data_i(rx_data_i),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .lookup_id_o(lookup_id_o),
        .lookup_known_i(lookup_known_i), .lookup_rx_len_i(lookup_rx_len_i),
        .lookup_tx_len_i(lookup_tx_len_i), .exec_id_o(exec_id_o), .exec_valid_o(exec_valid_o),
        .exec_data_o(exec_data_o), .exec_data_valid_o(exec_data_valid_o),
        .reply_req_o(reply_req_o), .reply_data_i(reply_data_i), .tx_data_o(tx_data_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .cmd_err_flag_o(cmd_err_flag_o),
        .data_err_flag_o(data_err_flag_o), .flags_clr_i(flags_clr_i));
    host_model HOST (
        .ref_clk_i(ref_clk_i), .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o),
        .tx_valid_o(tx_valid_o), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
        .tx_ready_i(tx_ready_i));
    // =====================================
    // helpers
    function automatic byte_q_t w2q(input logic [31:0] w);
        return '{w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    function automatic logic [15:0] frame_checksum_function(input byte_q_t q);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expect_bytes(input byte_q_t q);
        logic [7:0] b;
        logic       ok;
        foreach (q[i]) begin
            HOST.recv(b, ok);
            while (i == 0 && q[0] != 8'h00 && ok && b == 8'h00) HOST.recv(b, ok);
            check({ok, b}, {1'b1, q[i]});
        end
    endtask
    // =====================================
    // scenarios
    task automatic t_zero;
        HOST.send_frame('{8'h00});
        expect_bytes('{8'h00});
    endtask
    task automatic t_unknown;
        int n;
        logic lost;
        n = exec_cnt;
        HOST.send_frame(w2q(32'h5a5a5a11));
        expect_bytes(w2q(32'h63727265));
        check(cmd_err_flag_o, 1'b1);
        check(exec_cnt, n);
        HOST.resync(lost);
        check(lost, 1'b0);
        flags_clr_i <= 1'b1;
        @(posedge ref_clk_i);
        flags_clr_i <= 1'b0;
        @(posedge ref_clk_i);
        check(cmd_err_flag_o, 1'b0);
    endtask
    task automatic t_plain;
        int n;
        n = exec_cnt;
        HOST.send_frame(w2q(ID_PLAIN));
        expect_bytes(w2q(ID_PLAIN));
        check(exec_cnt, n + 1);
        check(exec_id_o, ID_PLAIN);
    endtask
    // a zero inside the data must not be taken for a resync byte
    task automatic t_data(input logic bad);
        byte_q_t d, r;
        logic [15:0] c, rc;
        int n, m;
        d = '{8'h12, 8'h00};
        r = '{8'ha0, 8'ha1};
        c = frame_checksum_function(d) ^ {15'h0, bad};
        rc = frame_checksum_function(r);
        n = exec_cnt;
        m = data_cnt;
        HOST.stall = !bad;
        HOST.send_frame({w2q(ID_DATA), d, c[7:0], c[15:8]});
        if (bad) expect_bytes(w2q(32'h64727265));
        else expect_bytes({w2q(ID_DATA), r, rc[7:0], rc[15:8]});
        HOST.stall = 1'b0;
        check(exec_cnt, n + (bad ? 0 : 1));
        check(data_cnt, m + 2);
        check(data_last, d[1]);
        check(data_err_flag_o, bad);
    endtask
    task automatic t_timeout;
        HOST.send_frame('{8'h61, 8'h70});
        repeat (TO_CYC + 5) @(posedge ref_clk_i);
        check(tx_valid_o, 1'b0);
        t_zero();
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        give_verdict();
    end
    initial begin
        reset_i = 1'b1;
        flags_clr_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        t_zero();
        t_unknown();
        t_plain();
        t_data(1'b0);
        t_data(1'b1);
        t_timeout();
        t_plain();
        give_verdict();
    end
endmodule // serial_command_framer_resync_tb
